// ===== tb/efs_load.sv
// Purpose: switched loads with current sense on eight channels
// Assumes: the bench sets what each load would draw
// Notes:   an open switch draws nothing, so its sense reads zero
`timescale 1ns/1ns
module efs_load (
    input  wire logic                          i_clk,
    input  wire logic [efs_pkg::NCH-1:0]       i_on,
    input  wire logic [efs_pkg::NCH-1:0][16:0] i_draw,
    output logic      [efs_pkg::NCH-1:0][16:0] o_cur_ma
);
    // ==========================================
    // sense path, one cycle late like a sampled converter
    always_ff @(posedge i_clk) begin
        for (int n = 0; n < efs_pkg::NCH; n++) begin
            o_cur_ma[n] <= i_on[n] ? i_draw[n] : 17'h00000;
        end
    end
endmodule

// ===== tb/efs_top_test.sv
// Purpose: self-checking bench of the eight channel fuse
// Assumes: ticks shortened to 2 clocks per us, 10 clocks per ms
// Notes:   channel 0 trips and locks, channel 1 runs in manual mode
`timescale 1ns/1ns
module efs_top_test;
    // ==========================================
    // signals
    logic                          i_clk, i_rst, i_wr, i_rd, o_irq;
    logic [8:0]                    i_addr;
    logic [31:0]                   i_wdata, o_rdata, rd_val;
    logic [efs_pkg::NCH-1:0]       i_evt_on, o_chan_on, o_fault;
    logic [efs_pkg::NCH-1:0][16:0] cur_ma, draw;
    logic [15:0]                   seed;
    int                            mismatches, samples_checked, exp_ma, k;
    efs_top #(.US_CYCLES(2), .MS_USEC(5)) dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_evt_on(i_evt_on), .i_cur_ma(cur_ma), .o_chan_on(o_chan_on),
        .o_fault(o_fault), .o_irq(o_irq));
    efs_load load (.i_clk(i_clk), .i_on(o_chan_on), .i_draw(draw), .o_cur_ma(cur_ma));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // ==========================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd(input logic [8:0] a);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rd_val = o_rdata;
    endtask
    task automatic close_out;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        {i_wr, i_rd, i_addr, i_wdata, i_evt_on} = '0;
        draw = '0;
        i_rst = 1'b1;
        {mismatches, samples_checked} = '0;
        seed = lfsr(16'hb94e);
        exp_ma = 1000 + seed % 10000;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(9'h108); chk("arm_ms", 32'h000000fa, rd_val);
        rd(9'h0f0); chk("unmapped", 32'h0, rd_val);
        wr(9'h114, 32'h0);
        @(posedge i_clk);
        draw[0] <= exp_ma[16:0];
        i_evt_on[1:0] <= 2'h3;
        repeat (20) @(posedge i_clk);
        rd(9'h11c); chk("cur_ma", exp_ma, rd_val);
        @(posedge i_clk);
        draw[0] <= 17'h1d4c0;
        repeat (1900) @(posedge i_clk);
        #1 chk("inrush", 32'h3, {o_fault, o_chan_on});
        for (k = 0; k < 300 && o_fault[0] !== 1'b1; k++) @(posedge i_clk);
        if (k == 300) begin
            mismatches++;
            close_out();
        end
        repeat (50) @(posedge i_clk);
        #1 chk("lock", 32'h102, {o_fault, o_chan_on});
        rd(9'h00c); chk("irq_stat", 32'h101, rd_val);
        wr(9'h010, 32'h1);
        repeat (3) @(posedge i_clk);
        chk("irq", 1, o_irq);
        wr(9'h00c, 32'h101);
        repeat (3) @(posedge i_clk);
        chk("irq_clr", 0, o_irq);
        draw[0] <= 17'h003e8;
        i_evt_on[0] <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_evt_on[0] <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1 chk("reon", 32'h3, {o_fault, o_chan_on});
        // channel 2 overloads the continuous limit and retries once, channel 3 overruns its fuse
        wr(9'h140, 32'h0);
        rd(9'h140); chk("win_clamp", efs_pkg::WIN_MIN_US, rd_val);
        wr(9'h144, 32'h0);
        wr(9'h154, 32'h1);
        wr(9'h158, 32'h2);
        wr(9'h168, 32'h0);
        wr(9'h16c, 32'h1388);
        wr(9'h170, 32'h3e8);
        rd(9'h170); chk("ovr_clamp", efs_pkg::OVR_MAX_MS, rd_val);
        @(posedge i_clk);
        draw[3:2] <= {17'h01f40, 17'h04e20};
        i_evt_on[3:2] <= 2'h3;
        repeat (2200) @(posedge i_clk);
        rd(9'h00c); chk("cont_trip", 32'h004, rd_val);
        repeat (400) @(posedge i_clk);
        rd(9'h00c); chk("fuse_trip", 32'h00c, rd_val);
        repeat (1600) @(posedge i_clk);
        rd(9'h00c); chk("retry_lock", 32'h40c, rd_val);
        #1 chk("retry_state", 32'h0c0b, {o_fault, o_chan_on});
        wr(9'h000, 32'h1);
        repeat (2) @(posedge i_clk);
        #1 chk("man_off", 0, o_chan_on);
        for (k = 0; k < 2; k++) begin
            wr(9'h004, 32'h2);
            repeat (2) @(posedge i_clk);
            #1 chk("man_tog", k ? 0 : 2, o_chan_on);
        end
        close_out();
    end
endmodule

// ===== verilog/efs_chan.sv
// Purpose: one switched channel with staged overcurrent protection and retries
// Assumes: current sample and command come from logic on the same clock
// Notes:   all timers restart at every switch-on, including a retry
`timescale 1ns/1ns
module efs_chan (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_us_tick,
    input  wire logic                 i_ms_tick,
    input  wire logic                 i_cmd_on,
    input  wire efs_pkg::efs_cfg_type i_cfg,
    input  wire logic [16:0]          i_cur_ma,
    output logic                      o_on,
    output logic                      o_fault,
    output logic                      o_trip,
    output logic                      o_lock
);
    efs_pkg::efs_state_type st_r;
    logic [10:0] cyc_r;
    logic [17:0] us_r;
    logic [13:0] ms_r;
    logic [7:0]  ovr_r;
    logic [15:0] wait_r;
    logic [3:0]  rty_r;
    logic [16:0] lim_ma;
    logic        over_fuse;
    logic        trip_now;

    // ==========================================================
    // trip conditions
    always_comb begin
        case (i_cfg.lim_sel)
            2'h0:    lim_ma = efs_pkg::CONT_MA_15;
            2'h1:    lim_ma = efs_pkg::CONT_MA_20;
            default: lim_ma = efs_pkg::CONT_MA_25;
        endcase
    end

    assign over_fuse = (ms_r >= i_cfg.arm_ms) && (i_cur_ma > {1'b0, i_cfg.fuse_ma});
    assign trip_now  = (i_cur_ma >= efs_pkg::HARD_MA)
                    || ((us_r >= i_cfg.win_us) && (i_cur_ma >= lim_ma))
                    || (ovr_r >= i_cfg.ovr_ms);

    // ==========================================================
    // timers
    always_ff @(posedge i_clk) begin
        if (i_rst || !o_on) begin
            cyc_r <= 11'h000;
            us_r  <= 18'h00000;
            ms_r  <= 14'h0000;
            ovr_r <= 8'h00;
        end else begin
            if (cyc_r != 11'(efs_pkg::INRUSH_CYC - 1)) begin
                cyc_r <= cyc_r + 11'h001;
            end
            if (i_us_tick && us_r != 18'h3ffff) begin
                us_r <= us_r + 18'h00001;
            end
            // arming time saturates so that a long-lived channel stays armed
            if (i_ms_tick && ms_r != 14'h3fff) begin
                ms_r <= ms_r + 14'h0001;
            end
            if (!over_fuse) begin
                ovr_r <= 8'h00;
            end else if (i_ms_tick && ovr_r != 8'hff) begin
                ovr_r <= ovr_r + 8'h01;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || st_r != efs_pkg::st_wait) begin
            wait_r <= 16'h0000;
        end else if (i_ms_tick && wait_r != 16'hffff) begin
            wait_r <= wait_r + 16'h0001;
        end
    end

    // ==========================================================
    // switching state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_r    <= efs_pkg::st_off;
            o_on    <= 1'b0;
            o_fault <= 1'b0;
            o_trip  <= 1'b0;
            o_lock  <= 1'b0;
            rty_r   <= 4'h0;
        end else begin
            o_trip <= 1'b0;
            o_lock <= 1'b0;
            case (st_r)
                efs_pkg::st_off: begin
                    if (i_cmd_on) begin
                        st_r    <= efs_pkg::st_inrush;
                        o_on    <= 1'b1;
                        o_fault <= 1'b0;
                        rty_r   <= 4'h0;
                    end
                end
                efs_pkg::st_inrush: begin
                    if (!i_cmd_on) begin
                        st_r <= efs_pkg::st_off;
                        o_on <= 1'b0;
                    end else if (cyc_r == 11'(efs_pkg::INRUSH_CYC - 1)) begin
                        st_r <= efs_pkg::st_run;
                    end
                end
                efs_pkg::st_run: begin
                    if (!i_cmd_on) begin
                        st_r <= efs_pkg::st_off;
                        o_on <= 1'b0;
                    end else if (trip_now) begin
                        o_on    <= 1'b0;
                        o_fault <= 1'b1;
                        o_trip  <= 1'b1;
                        if (rty_r < i_cfg.retry_max) begin
                            st_r  <= efs_pkg::st_wait;
                            rty_r <= rty_r + 4'h1;
                        end else begin
                            st_r   <= efs_pkg::st_lock;
                            o_lock <= 1'b1;
                        end
                    end
                end
                efs_pkg::st_wait: begin
                    if (!i_cmd_on) begin
                        st_r <= efs_pkg::st_off;
                    end else if (wait_r >= i_cfg.retry_interval) begin
                        st_r <= efs_pkg::st_inrush;
                        o_on <= 1'b1;
                    end
                end
                efs_pkg::st_lock: begin
                    // fault stays up; only a fresh on command clears it
                    if (!i_cmd_on) begin
                        st_r <= efs_pkg::st_off;
                    end
                end
                default: begin
                    st_r <= efs_pkg::st_off;
                    o_on <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_tripped;
        !o_on && o_fault;
    endsequence

    a_inrush_blank: assert property ((st_r == efs_pkg::st_inrush) && i_cmd_on |=> o_on)
        else $error("channel dropped during inrush blanking");
    a_hard_trip: assert property ((st_r == efs_pkg::st_run) && i_cmd_on
                                  && (i_cur_ma >= efs_pkg::HARD_MA) |=> s_tripped)
        else $error("hard limit did not trip");
    a_cont_trip: assert property ((st_r == efs_pkg::st_run) && i_cmd_on
                                  && (us_r >= i_cfg.win_us) && (i_cur_ma >= lim_ma) |=> s_tripped)
        else $error("continuous limit did not trip");
    a_retry_gap: assert property ($rose(st_r == efs_pkg::st_wait) |-> !o_on
                                  throughout (st_r == efs_pkg::st_wait))
        else $error("channel on while waiting to retry");
    a_lock_count: assert property ($rose(o_lock) |-> (rty_r == i_cfg.retry_max)
                                   ##0 s_tripped)
        else $error("locked before retries were used");
    a_lock_hold: assert property ((st_r == efs_pkg::st_lock) |=> o_fault && !o_on)
        else $error("locked channel lost its fault or switched on");
endmodule

// ===== verilog/efs_pkg.sv
// Purpose: shared constants, types and register map of the eight channel electronic fuse
// Assumes: 100 MHz clock, current samples in mA from logic on the same clock
// Notes:   count constants derive from the printed times and the clock rate
package efs_pkg;

    // ==========================================================
    // sizes and timing
    localparam int NCH        = 8;
    localparam int CLK_HZ     = 100_000_000;
    localparam int CLK_MHZ    = CLK_HZ / 1_000_000;
    localparam int INRUSH_US  = 20;
    localparam int INRUSH_CYC = INRUSH_US * CLK_MHZ;
    localparam int US_CYC     = CLK_MHZ;
    localparam int MS_US      = 1000;

    // ==========================================================
    // current thresholds and setting bounds
    localparam logic [16:0] HARD_MA     = 17'h186a0;
    localparam logic [16:0] CONT_MA_15  = 17'h03a98;
    localparam logic [16:0] CONT_MA_20  = 17'h04e20;
    localparam logic [16:0] CONT_MA_25  = 17'h061a8;
    localparam logic [31:0] FUSE_MAX_MA = 32'h0000c350;
    localparam logic [31:0] ARM_MAX_MS  = 32'h00002710;
    localparam logic [31:0] WIN_MIN_US  = 32'h00000096;
    localparam logic [31:0] WIN_MAX_US  = 32'h00025d78;
    localparam logic [31:0] OVR_MIN_MS  = 32'h00000019;
    localparam logic [31:0] OVR_MAX_MS  = 32'h000000fa;
    localparam logic [31:0] LIM_SEL_MAX = 32'h00000002;

    // ==========================================================
    // register map
    localparam logic [8:0] OFF_CTRL     = 9'h000;
    localparam logic [8:0] OFF_MAN_CMD  = 9'h004;
    localparam logic [8:0] OFF_STATUS   = 9'h008;
    localparam logic [8:0] OFF_IRQ_STAT = 9'h00c;
    localparam logic [8:0] OFF_IRQ_MASK = 9'h010;
    localparam int         CH_BASE_BIT  = 8;
    localparam int         CTRL_MAN_BIT = 0;
    localparam logic [4:0] F_WIN        = 5'h00;
    localparam logic [4:0] F_LIM        = 5'h04;
    localparam logic [4:0] F_ARM        = 5'h08;
    localparam logic [4:0] F_FUSE       = 5'h0c;
    localparam logic [4:0] F_OVR        = 5'h10;
    localparam logic [4:0] F_RMAX       = 5'h14;
    localparam logic [4:0] F_RMS        = 5'h18;
    localparam logic [4:0] F_CUR        = 5'h1c;

    // ==========================================================
    // per channel settings and their reset values
    typedef struct packed {
        logic [17:0] win_us;
        logic [1:0]  lim_sel;
        logic [13:0] arm_ms;
        logic [15:0] fuse_ma;
        logic [7:0]  ovr_ms;
        logic [3:0]  retry_max;
        logic [15:0] retry_interval;
    } efs_cfg_type;

    localparam efs_cfg_type CFG_RST = '{
        win_us:    18'h02710,
        lim_sel:   2'h2,
        arm_ms:    14'h00fa,
        fuse_ma:   16'h3a98,
        ovr_ms:    8'h19,
        retry_max: 4'h3,
        retry_interval:  16'h0064
    };

    typedef enum logic [2:0] {
        st_off,
        st_inrush,
        st_run,
        st_wait,
        st_lock
    } efs_state_type;

endpackage

// ===== verilog/efs_tick.sv
// Purpose: microsecond and millisecond enable pulses
// Assumes: one clock, synchronous reset
// Notes:   both divisors are parameters so simulation can shorten them
`timescale 1ns/1ns
module efs_tick #(
    parameter int US_CYCLES = efs_pkg::US_CYC,
    parameter int MS_USEC   = efs_pkg::MS_US
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    output logic      o_us,
    output logic      o_ms
);
    logic [15:0] cyc_r;
    logic [15:0] us_r;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cyc_r <= 16'h0000;
            us_r  <= 16'h0000;
            o_us  <= 1'b0;
            o_ms  <= 1'b0;
        end else begin
            o_us <= 1'b0;
            o_ms <= 1'b0;
            if (cyc_r == 16'(US_CYCLES - 1)) begin
                cyc_r <= 16'h0000;
                o_us  <= 1'b1;
                if (us_r == 16'(MS_USEC - 1)) begin
                    us_r <= 16'h0000;
                    o_ms <= 1'b1;
                end else begin
                    us_r <= us_r + 16'h0001;
                end
            end else begin
                cyc_r <= cyc_r + 16'h0001;
            end
        end
    end
endmodule

// ===== verilog/efs_top.sv
// Purpose: eight channel electronic fuse with register port and interrupt
// Assumes: event commands and current samples are on i_clk
// Notes:   out-of-range settings are clamped on write, never rejected
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module efs_top #(
    parameter int US_CYCLES = efs_pkg::US_CYC,
    parameter int MS_USEC   = efs_pkg::MS_US
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_rst,
    input  wire logic [8:0]                  i_addr,
    input  wire logic [31:0]                 i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output logic      [31:0]                 o_rdata,
    input  wire logic [efs_pkg::NCH-1:0]     i_evt_on,
    input  wire logic [efs_pkg::NCH-1:0][16:0] i_cur_ma,
    output logic      [efs_pkg::NCH-1:0]     o_chan_on,
    output logic      [efs_pkg::NCH-1:0]     o_fault,
    output logic                             o_irq
);
    localparam int N = efs_pkg::NCH;

    logic                 us_tick;
    logic                 ms_tick;
    logic                 man_mode_r;
    logic [N-1:0]         man_state_r;
    logic [N-1:0]         cmd_on;
    logic [N-1:0]         trip;
    logic [N-1:0]         lock;
    efs_pkg::efs_cfg_type cfg_r [N];
    logic [16:0]          cur_r [N];
    logic [15:0]          irq_stat_r;
    logic [15:0]          irq_mask_r;
    logic [15:0]          irq_clr;
    logic [31:0]          rd_nxt;
    logic                 wr_glob;
    logic                 wr_chan;
    logic [2:0]           ch_sel;
    logic [4:0]           fld;

    function automatic logic [31:0] efs_clamp(input logic [31:0] v,
                                              input logic [31:0] lo,
                                              input logic [31:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    assign wr_glob = i_wr && !i_addr[efs_pkg::CH_BASE_BIT];
    assign wr_chan = i_wr && i_addr[efs_pkg::CH_BASE_BIT];
    assign ch_sel  = i_addr[7:5];
    assign fld     = i_addr[4:0];

    // ==========================================================
    // time base
    efs_tick #(
        .US_CYCLES (US_CYCLES),
        .MS_USEC   (MS_USEC)
    ) u_tick (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .o_us  (us_tick),
        .o_ms  (ms_tick)
    );

    // ==========================================================
    // manual test mode
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            man_mode_r <= 1'b0;
        end else if (wr_glob && i_addr == efs_pkg::OFF_CTRL) begin
            man_mode_r <= i_wdata[efs_pkg::CTRL_MAN_BIT];
        end
    end

    // held clear outside manual mode, so entering it starts with every channel off
    always_ff @(posedge i_clk) begin
        if (i_rst || !man_mode_r) begin
            man_state_r <= '0;
        end else if (wr_glob && i_addr == efs_pkg::OFF_MAN_CMD) begin
            man_state_r <= man_state_r ^ i_wdata[N-1:0];
        end
    end

    assign cmd_on = man_mode_r ? man_state_r : i_evt_on;

    // ==========================================================
    // channel settings and current capture
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int k = 0; k < N; k++) begin
                cfg_r[k] <= efs_pkg::CFG_RST;
            end
        end else if (wr_chan) begin
            case (fld)
                efs_pkg::F_WIN:  cfg_r[ch_sel].win_us  <= 18'(efs_clamp(i_wdata,
                                     efs_pkg::WIN_MIN_US, efs_pkg::WIN_MAX_US));
                efs_pkg::F_LIM:  cfg_r[ch_sel].lim_sel <= 2'(efs_clamp(i_wdata,
                                     32'h0, efs_pkg::LIM_SEL_MAX));
                efs_pkg::F_ARM:  cfg_r[ch_sel].arm_ms  <= 14'(efs_clamp(i_wdata,
                                     32'h0, efs_pkg::ARM_MAX_MS));
                efs_pkg::F_FUSE: cfg_r[ch_sel].fuse_ma <= 16'(efs_clamp(i_wdata,
                                     32'h0, efs_pkg::FUSE_MAX_MA));
                efs_pkg::F_OVR:  cfg_r[ch_sel].ovr_ms  <= 8'(efs_clamp(i_wdata,
                                     efs_pkg::OVR_MIN_MS, efs_pkg::OVR_MAX_MS));
                efs_pkg::F_RMAX: cfg_r[ch_sel].retry_max <= i_wdata[3:0];
                efs_pkg::F_RMS:  cfg_r[ch_sel].retry_interval  <= i_wdata[15:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int k = 0; k < N; k++) begin
                cur_r[k] <= 17'h00000;
            end
        end else begin
            for (int k = 0; k < N; k++) begin
                cur_r[k] <= i_cur_ma[k];
            end
        end
    end

    // ==========================================================
    // channels
    for (genvar g = 0; g < N; g++) begin : g_chan
        efs_chan u_chan (
            .i_clk     (i_clk),
            .i_rst     (i_rst),
            .i_us_tick (us_tick),
            .i_ms_tick (ms_tick),
            .i_cmd_on  (cmd_on[g]),
            .i_cfg     (cfg_r[g]),
            .i_cur_ma  (i_cur_ma[g]),
            .o_on      (o_chan_on[g]),
            .o_fault   (o_fault[g]),
            .o_trip    (trip[g]),
            .o_lock    (lock[g])
        );
    end

    // ==========================================================
    // interrupt: trips in the low byte, lockouts in the high byte
    assign irq_clr = (wr_glob && i_addr == efs_pkg::OFF_IRQ_STAT) ? i_wdata[15:0] : 16'h0000;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_stat_r <= 16'h0000;
        end else begin
            // a new event beats a clear in the same cycle
            irq_stat_r <= (irq_stat_r & ~irq_clr) | {lock, trip};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_mask_r <= 16'h0000;
        end else if (wr_glob && i_addr == efs_pkg::OFF_IRQ_MASK) begin
            irq_mask_r <= i_wdata[15:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ==========================================================
    // read port
    always_comb begin
        rd_nxt = 32'h00000000;
        if (i_addr[efs_pkg::CH_BASE_BIT]) begin
            case (fld)
                efs_pkg::F_WIN:  rd_nxt = 32'(cfg_r[ch_sel].win_us);
                efs_pkg::F_LIM:  rd_nxt = 32'(cfg_r[ch_sel].lim_sel);
                efs_pkg::F_ARM:  rd_nxt = 32'(cfg_r[ch_sel].arm_ms);
                efs_pkg::F_FUSE: rd_nxt = 32'(cfg_r[ch_sel].fuse_ma);
                efs_pkg::F_OVR:  rd_nxt = 32'(cfg_r[ch_sel].ovr_ms);
                efs_pkg::F_RMAX: rd_nxt = 32'(cfg_r[ch_sel].retry_max);
                efs_pkg::F_RMS:  rd_nxt = 32'(cfg_r[ch_sel].retry_interval);
                efs_pkg::F_CUR:  rd_nxt = 32'(cur_r[ch_sel]);
                default:         rd_nxt = 32'h00000000;
            endcase
        end else begin
            case (i_addr)
                efs_pkg::OFF_CTRL:     rd_nxt = 32'(man_mode_r);
                efs_pkg::OFF_MAN_CMD:  rd_nxt = 32'(man_state_r);
                efs_pkg::OFF_STATUS:   rd_nxt = {16'h0000, o_fault, o_chan_on};
                efs_pkg::OFF_IRQ_STAT: rd_nxt = {16'h0000, irq_stat_r};
                efs_pkg::OFF_IRQ_MASK: rd_nxt = {16'h0000, irq_mask_r};
                default:               rd_nxt = 32'h00000000;
            endcase
        end
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_rd) begin
            o_rdata <= 32'h00000000;
        end else begin
            o_rdata <= rd_nxt;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_manual_off: assert property ($rose(man_mode_r) |=> (o_chan_on == '0))
        else $error("a channel stayed on after entering manual mode");
    // a command word flips exactly the channels whose bits are set
    a_manual_toggle: assert property (man_mode_r && wr_glob
                                      && (i_addr == efs_pkg::OFF_MAN_CMD)
                                      |=> man_state_r == ($past(man_state_r)
                                                          ^ $past(i_wdata[N-1:0])))
        else $error("manual command did not toggle the addressed channels");
    a_fuse_cap: assert property (cfg_r[0].fuse_ma <= 16'(efs_pkg::FUSE_MAX_MA))
        else $error("fuse level above its ceiling");
    a_arm_cap: assert property (cfg_r[0].arm_ms <= 14'(efs_pkg::ARM_MAX_MS))
        else $error("arming delay above its ceiling");
    a_irq_level: assert property (|(irq_stat_r & irq_mask_r) |=> o_irq)
        else $error("interrupt not raised for an unmasked event");
    a_read_slot: assert property (!i_rd |=> (o_rdata == 32'h00000000))
        else $error("read data outside the answer cycle");
endmodule
